// ### rtl/ufp_pkg.sv
// constants, register map and pin carriers of the usb fifo parallel port
// assumes a 50 MHz aclk and a 32-bit axi4-lite register bus
package ufp_pkg;

	localparam int unsigned UFP_CLK_HZ = 50_000_000;
	localparam int unsigned UFP_WAKE_MS = 20;
	// least time, whole cycles, no rounding term added
	localparam int unsigned UFP_WAKE_CYC =
		(UFP_CLK_HZ / 1000 * UFP_WAKE_MS + 0) ;
	localparam int unsigned UFP_BYTE_W = 8;

	// register byte offsets
	localparam logic [7:0] UFP_OFF_CFG = 8'h00;
	localparam logic [7:0] UFP_OFF_STAT = 8'h04;
	localparam logic [7:0] UFP_OFF_ERR = 8'h08;
	localparam logic [7:0] UFP_OFF_CNT = 8'h0c;

	// cfg fields
	localparam int unsigned UFP_CFG_WAKE = 0;
	localparam int unsigned UFP_CFG_PULL = 1;
	localparam logic [1:0] UFP_CFG_RST = 2'h0;

	// stat fields
	localparam int unsigned UFP_ST_RX_FLAG = 0;
	localparam int unsigned UFP_ST_TX_FLAG = 1;
	localparam int unsigned UFP_ST_PWR = 2;
	localparam int unsigned UFP_ST_SUSP = 3;
	localparam int unsigned UFP_ST_WAKEIN = 4;

	// err fields, write one to clear
	localparam int unsigned UFP_ERR_WOVR = 0;
	localparam int unsigned UFP_ERR_RUND = 1;
	localparam int unsigned UFP_ERR_WAKE = 2;

	localparam logic [15:0] UFP_CNT_RST = 16'h0000;
	localparam logic [1:0] UFP_RESP_OKAY = 2'h0;
	localparam logic [1:0] UFP_RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		UFP_BUS_IDLE = 1'b0,
		UFP_BUS_RESP = 1'b1
	} ufp_bus_st_t;

	typedef enum logic [1:0] {
		UFP_REG_CFG = 2'b00,
		UFP_REG_STAT = 2'b01,
		UFP_REG_ERR = 2'b10,
		UFP_REG_CNT = 2'b11
	} ufp_reg_t;

	typedef struct packed {
		logic rd_n;
		logic wr;
		logic [UFP_BYTE_W-1:0] byte_bus_in;
		logic rx_data_flag_n_in;
	} ufp_pin_in_t;

	typedef struct packed {
		logic [UFP_BYTE_W-1:0] byte_bus_out;
		logic byte_bus_oe_n;
		logic tx_space_flag_n;
		logic tx_space_flag_oe_n;
		logic rx_data_flag_n;
		logic rx_data_flag_oe_n;
		logic pull_low;
		logic power_enable_n;
	} ufp_pin_out_t;

endpackage

// ### rtl/ufp_port.sv
// usb fifo parallel port: byte-wide strobed fifo interface toward an
// external controller, with power enable, remote wakeup and pull option
// assumes strobes synchronous to aclk and a usb engine that streams bytes
// Overview of operation
// - while read strobe is low, drive current receive byte; otherwise release bus.
// - read strobe falling edge advances to next receive byte, when one exists.
// - write strobe falling edge captures bus byte into transmit buffer, when it is empty.
// - transmit flag low when a byte fits; far side writes only then.
// - receive flag low while unread bytes exist; far side reads only then.
// - both flag pins float while the device is in reset.
// - power enable goes low after configuration, high again on suspend.
// - wakeup enabled and suspended turns receive flag pin into an input.
// - receive flag held low 20 ms while suspended requests usb resume.
// - pull-low option pulls interface inputs low during suspend, else high.
// - active-low reset input resets the device; unused it stays high.
`timescale 1ns/10ps
`default_nettype none

module ufp_port
	import ufp_pkg::*;
#(
	parameter int unsigned WAKE_CYC = ufp_pkg::UFP_WAKE_CYC,
	parameter int unsigned ADDR_W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// fifo pins
	input wire ufp_pkg::ufp_pin_in_t pin_i,
	output ufp_pkg::ufp_pin_out_t pin_o,
	// usb engine side
	input wire logic usb_configured,
	input wire logic usb_suspend,
	input wire logic usb_rx_valid,
	input wire logic [ufp_pkg::UFP_BYTE_W-1:0] usb_rx_data,
	output logic usb_rx_ready,
	output logic usb_tx_valid,
	output logic [ufp_pkg::UFP_BYTE_W-1:0] usb_tx_data,
	input wire logic usb_tx_ready,
	output logic usb_resume_req,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ufp_pkg::*;

	localparam int unsigned WCNT_W = $clog2(WAKE_CYC + 1);

	// word decode shared by both bus directions
	function automatic logic ufp_hit(input logic [ADDR_W-1:0] a,
			output ufp_reg_t r);
		logic [7:0] o;
		o = 8'(a);
		r = UFP_REG_CFG;
		ufp_hit = 1'b1;
		case (o)
			UFP_OFF_CFG: r = UFP_REG_CFG;
			UFP_OFF_STAT: r = UFP_REG_STAT;
			UFP_OFF_ERR: r = UFP_REG_ERR;
			UFP_OFF_CNT: r = UFP_REG_CNT;
			default: ufp_hit = 1'b0;
		endcase
	endfunction

	logic [1:0] cfg_q;
	logic [2:0] err_q;
	logic [15:0] rx_cnt_q;
	logic [15:0] tx_cnt_q;
	logic rd_n_q;
	logic wr_q;
	logic rd_fall;
	logic wr_fall;
	logic [UFP_BYTE_W-1:0] rx_q;
	logic rx_full_q;
	logic [UFP_BYTE_W-1:0] out_q;
	logic [UFP_BYTE_W-1:0] tx_q;
	logic tx_full_q;
	logic pwr_n_q;
	logic wake_mode;
	logic [WCNT_W-1:0] wake_cnt_q;
	logic wake_done_q;
	logic resume_q;
	logic rx_pop;
	logic tx_pop;

	// strobe edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_n_q <= 1'b1;
			wr_q <= 1'b0;
		end else begin
			rd_n_q <= pin_i.rd_n;
			wr_q <= pin_i.wr;
		end
	end

	assign rd_fall = rd_n_q & ~pin_i.rd_n;
	assign wr_fall = wr_q & ~pin_i.wr;
	assign rx_pop = rd_fall & rx_full_q;
	assign tx_pop = usb_tx_valid & usb_tx_ready;

	// receive holding byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_q <= '0;
			rx_full_q <= 1'b0;
		end else if (rx_pop) begin
			rx_full_q <= 1'b0;
		end else if (usb_rx_valid && !rx_full_q) begin
			rx_q <= usb_rx_data;
			rx_full_q <= 1'b1;
		end
	end

	assign usb_rx_ready = aresetn & ~rx_full_q;

	// byte presented while read strobe is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= '0;
		end else if (rx_pop) begin
			out_q <= rx_q;
		end
	end

	// transmit holding byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_q <= '0;
			tx_full_q <= 1'b0;
		end else if (wr_fall && !tx_full_q) begin
			tx_q <= pin_i.byte_bus_in;
			tx_full_q <= 1'b1;
		end else if (tx_pop) begin
			tx_full_q <= 1'b0;
		end
	end

	assign usb_tx_valid = tx_full_q;
	assign usb_tx_data = tx_q;

	// power enable follows configuration and suspend
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_n_q <= 1'b1;
		end else if (usb_suspend) begin
			pwr_n_q <= 1'b1;
		end else if (usb_configured) begin
			pwr_n_q <= 1'b0;
		end
	end

	assign wake_mode = cfg_q[UFP_CFG_WAKE] & pwr_n_q & usb_suspend;

	// remote wakeup low-time counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_cnt_q <= '0;
			wake_done_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			resume_q <= 1'b0;
			if (!wake_mode || pin_i.rx_data_flag_n_in) begin
				wake_cnt_q <= '0;
				wake_done_q <= 1'b0;
			end else if (!wake_done_q) begin
				if (wake_cnt_q == WCNT_W'(WAKE_CYC - 1)) begin
					wake_done_q <= 1'b1;
					resume_q <= 1'b1;
				end else begin
					wake_cnt_q <= wake_cnt_q + 1'b1;
				end
			end
		end
	end

	assign usb_resume_req = resume_q;

	// pin drive
	always_comb begin
		pin_o.byte_bus_out = rd_fall ? rx_q : out_q;
		pin_o.byte_bus_oe_n = ~aresetn | pin_i.rd_n;
		pin_o.tx_space_flag_n = tx_full_q;
		pin_o.tx_space_flag_oe_n = ~aresetn;
		pin_o.rx_data_flag_n = ~rx_full_q;
		pin_o.rx_data_flag_oe_n = ~aresetn | wake_mode;
		pin_o.pull_low = cfg_q[UFP_CFG_PULL] & usb_suspend;
		pin_o.power_enable_n = pwr_n_q;
	end

	// axi write path
	ufp_bus_st_t wst_q;
	logic aw_got_q;
	logic w_got_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] bresp_q;
	ufp_reg_t wreg;
	logic whit;
	logic wdo;
	logic [2:0] err_clr;

	assign s_axi_awready = (wst_q == UFP_BUS_IDLE) & ~aw_got_q;
	assign s_axi_wready = (wst_q == UFP_BUS_IDLE) & ~w_got_q;
	assign wdo = (wst_q == UFP_BUS_IDLE) & aw_got_q & w_got_q;

	always_comb begin
		wreg = UFP_REG_CFG;
		whit = ufp_hit(awaddr_q, wreg);
		err_clr = '0;
		if (wdo && whit && wreg == UFP_REG_ERR && wstrb_q[0]) begin
			err_clr = wdata_q[2:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_q <= UFP_BUS_IDLE;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bresp_q <= UFP_RESP_OKAY;
		end else begin
			case (wst_q)
				UFP_BUS_IDLE: begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_got_q <= 1'b1;
						awaddr_q <= s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_got_q <= 1'b1;
						wdata_q <= s_axi_wdata;
						wstrb_q <= s_axi_wstrb;
					end
					if (wdo) begin
						wst_q <= UFP_BUS_RESP;
						bresp_q <= whit ? UFP_RESP_OKAY : UFP_RESP_SLVERR;
					end
				end
				UFP_BUS_RESP: begin
					if (s_axi_bready) begin
						wst_q <= UFP_BUS_IDLE;
						aw_got_q <= 1'b0;
						w_got_q <= 1'b0;
					end
				end
				default: wst_q <= UFP_BUS_IDLE;
			endcase
		end
	end

	assign s_axi_bvalid = (wst_q == UFP_BUS_RESP);
	assign s_axi_bresp = bresp_q;

	// configuration register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q <= UFP_CFG_RST;
		end else if (wdo && whit && wreg == UFP_REG_CFG && wstrb_q[0]) begin
			cfg_q <= wdata_q[1:0];
		end
	end

	// sticky errors, a new event beats a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err_q <= '0;
		end else begin
			err_q[UFP_ERR_WOVR] <= (err_q[UFP_ERR_WOVR] & ~err_clr[UFP_ERR_WOVR])
				| (wr_fall & tx_full_q);
			err_q[UFP_ERR_RUND] <= (err_q[UFP_ERR_RUND] & ~err_clr[UFP_ERR_RUND])
				| (rd_fall & ~rx_full_q);
			err_q[UFP_ERR_WAKE] <= (err_q[UFP_ERR_WAKE] & ~err_clr[UFP_ERR_WAKE])
				| resume_q;
		end
	end

	// byte counters, wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_cnt_q <= UFP_CNT_RST;
			tx_cnt_q <= UFP_CNT_RST;
		end else begin
			if (rx_pop) begin
				rx_cnt_q <= rx_cnt_q + 16'h0001;
			end
			if (wr_fall && !tx_full_q) begin
				tx_cnt_q <= tx_cnt_q + 16'h0001;
			end
		end
	end

	// axi read path
	ufp_bus_st_t rst_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	ufp_reg_t rreg;
	logic rhit;
	logic [31:0] rword;

	always_comb begin
		rreg = UFP_REG_CFG;
		rhit = ufp_hit(s_axi_araddr, rreg);
		rword = '0;
		case (rreg)
			UFP_REG_CFG: rword[1:0] = cfg_q;
			UFP_REG_STAT: begin
				rword[UFP_ST_RX_FLAG] = ~rx_full_q;
				rword[UFP_ST_TX_FLAG] = tx_full_q;
				rword[UFP_ST_PWR] = pwr_n_q;
				rword[UFP_ST_SUSP] = usb_suspend;
				rword[UFP_ST_WAKEIN] = wake_mode;
			end
			UFP_REG_ERR: rword[2:0] = err_q;
			UFP_REG_CNT: rword = {tx_cnt_q, rx_cnt_q};
			default: rword = '0;
		endcase
		if (!rhit) begin
			rword = '0;
		end
	end

	assign s_axi_arready = (rst_q == UFP_BUS_IDLE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_q <= UFP_BUS_IDLE;
			rdata_q <= '0;
			rresp_q <= UFP_RESP_OKAY;
		end else begin
			case (rst_q)
				UFP_BUS_IDLE: begin
					if (s_axi_arvalid) begin
						rst_q <= UFP_BUS_RESP;
						rdata_q <= rword;
						rresp_q <= rhit ? UFP_RESP_OKAY : UFP_RESP_SLVERR;
					end
				end
				UFP_BUS_RESP: begin
					if (s_axi_rready) begin
						rst_q <= UFP_BUS_IDLE;
					end
				end
				default: rst_q <= UFP_BUS_IDLE;
			endcase
		end
	end

	assign s_axi_rvalid = (rst_q == UFP_BUS_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

// ### tb/ufp_sva.sv
// assertions on the fifo port pins and usb side
// bound into ufp_port, sees its ports only
`timescale 1ns/10ps
`default_nettype none
module ufp_sva
	import ufp_pkg::*;
#(
	parameter int unsigned WAKE_CYC = 16
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pins
	input wire ufp_pkg::ufp_pin_in_t pin_i,
	input wire ufp_pkg::ufp_pin_out_t pin_o,
	// usb side
	input wire logic usb_configured,
	input wire logic usb_suspend,
	input wire logic usb_tx_valid,
	input wire logic [ufp_pkg::UFP_BYTE_W-1:0] usb_tx_data,
	input wire logic usb_resume_req
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles the wake pin has been low
	logic [31:0] lo_q;
	always_ff @(posedge aclk) begin
		if (!aresetn || pin_i.rx_data_flag_n_in) begin
			lo_q <= 32'h0;
		end else begin
			lo_q <= lo_q + 32'h1;
		end
	end
	chk_bus_drive: assert property (
		pin_o.byte_bus_oe_n == pin_i.rd_n) else $error("bus drive wrong");
	chk_rd_hold: assert property (
		!pin_i.rd_n && !$past(pin_i.rd_n) |-> $stable(pin_o.byte_bus_out))
		else $error("read byte moved");
	chk_rx_pop: assert property (
		$fell(pin_i.rd_n) && !pin_o.rx_data_flag_n && !pin_o.rx_data_flag_oe_n
		|=> pin_o.rx_data_flag_n) else $error("rx flag kept");
	chk_tx_take: assert property (
		$fell(pin_i.wr) && !pin_o.tx_space_flag_n |=> pin_o.tx_space_flag_n
		&& usb_tx_valid && usb_tx_data == $past(pin_i.byte_bus_in))
		else $error("tx byte lost");
	chk_flag_float: assert property (disable iff (1'b0)
		!aresetn |-> pin_o.tx_space_flag_oe_n && pin_o.rx_data_flag_oe_n)
		else $error("flag driven in reset");
	chk_pwr_on: assert property (
		usb_configured && !usb_suspend |=> !pin_o.power_enable_n)
		else $error("power not enabled");
	chk_pwr_off: assert property (
		usb_suspend |=> pin_o.power_enable_n) else $error("power kept in suspend");
	chk_wake_pin: assert property (
		!usb_suspend |-> !pin_o.rx_data_flag_oe_n) else $error("rx flag not driven");
	chk_pull_low: assert property (
		!usb_suspend |-> !pin_o.pull_low) else $error("pull low awake");
	chk_resume_wait: assert property (
		usb_resume_req |-> lo_q >= WAKE_CYC - 1) else $error("resume too early");
endmodule
bind ufp_port ufp_sva #(.WAKE_CYC(WAKE_CYC)) u_sva (.aclk, .aresetn, .pin_i, .pin_o,
	.usb_configured, .usb_suspend, .usb_tx_valid, .usb_tx_data, .usb_resume_req);
`default_nettype wire

// ### tb/ufp_ext.sv
// far-side controller model strobing the fifo pins
// assumes strobes synchronous to aclk, bus resolved here
`timescale 1ns/10ps
`default_nettype none
module ufp_ext
	import ufp_pkg::*;
(
	// clock
	input wire logic aclk,
	// pins
	input wire ufp_pkg::ufp_pin_out_t pin_o,
	output var ufp_pkg::ufp_pin_in_t pin_i
);
	logic rd_n_q = 1'b1;
	logic wr_q = 1'b0;
	logic wake_q = 1'b0;
	logic [7:0] drv_q = 8'h5a;
	// released flag pin: pulled high unless pull-low or wake drive
	assign pin_i = '{rd_n_q, wr_q, pin_o.byte_bus_oe_n ? drv_q : pin_o.byte_bus_out,
		pin_o.rx_data_flag_oe_n ? !(wake_q || pin_o.pull_low) : pin_o.rx_data_flag_n};
	task automatic rd(output logic [7:0] b);
		do @(posedge aclk); while (pin_i.rx_data_flag_n_in);
		rd_n_q <= 1'b0;
		@(posedge aclk);
		b = pin_i.byte_bus_in;
		rd_n_q <= 1'b1;
		@(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] b);
		// a floating flag reads high through its pull-up
		do @(posedge aclk); while (pin_o.tx_space_flag_oe_n || pin_o.tx_space_flag_n);
		wr_q <= 1'b1;
		drv_q <= b;
		@(posedge aclk);
		wr_q <= 1'b0;
		@(posedge aclk);
		drv_q <= ~b;
	endtask
	task automatic wake(input int n);
		wake_q <= 1'b1;
		repeat (n) @(posedge aclk);
		wake_q <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb/test_usb_fifo_parallel_port.sv
// bench of the fifo port: byte table, then registers and wakeup
// assumes ufp_ext on the pins, usb side driven here
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((e) !== (s)) begin n_errors++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module test_usb_fifo_parallel_port;
	import ufp_pkg::*;
	typedef struct packed {logic [7:0] rx; logic [7:0] tx;} ufp_row_t;
	ufp_row_t rows [4] = '{'{8'h00, 8'hff}, '{8'ha5, 8'h5a}, '{8'hff, 8'h00}, '{8'h81, 8'h7e}};
	int n_errors = 0, n_tests = 0, cyc = 0, n_res = 0;
	logic aclk = 1'b0, aresetn = 1'b0, cfgd = 1'b0, susp = 1'b0;
	logic rxv = 1'b0, txr = 1'b0, rxr, txv, res;
	logic [7:0] rxd = 8'h00, txd, awa = 8'h00, ara = 8'h00, b;
	logic [31:0] wd = 32'h0, rdat;
	logic [3:0] ws = 4'hf;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic awr, wrr, bv, arr, rv;
	logic [1:0] br, rr;
	ufp_pin_in_t pin_i;
	ufp_pin_out_t pin_o;
	ufp_port #(.WAKE_CYC(16)) dut (.aclk, .aresetn, .pin_i, .pin_o, .usb_configured(cfgd),
		.usb_suspend(susp), .usb_rx_valid(rxv), .usb_rx_data(rxd), .usb_rx_ready(rxr),
		.usb_tx_valid(txv), .usb_tx_data(txd), .usb_tx_ready(txr), .usb_resume_req(res),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rre));
	ufp_ext ext (.aclk, .pin_o, .pin_i);
	always #10 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (res === 1'b1) n_res++;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end
	task automatic results();
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (!awr);
				awv <= 1'b0;
			end
			begin
				do @(posedge aclk); while (!wrr);
				wv <= 1'b0;
			end
		join
		while (!bv) @(posedge aclk);
		`CHK("bresp", er, br)
		bre <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		while (!rv) @(posedge aclk);
		`CHK("rdata", e, rdat)
		`CHK("rresp", er, rr)
		rre <= 1'b0;
	endtask
	task automatic pins(input logic pw, input logic fo, input logic pl);
		repeat (3) @(posedge aclk);
		`CHK("power", pw, pin_o.power_enable_n)
		`CHK("rx oe", fo, pin_o.rx_data_flag_oe_n)
		`CHK("pull", pl, pin_o.pull_low)
	endtask
	initial begin
		repeat (6) @(posedge aclk);
		`CHK("tx oe", 1'b1, pin_o.tx_space_flag_oe_n)
		`CHK("rx oe", 1'b1, pin_o.rx_data_flag_oe_n)
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		cfgd <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge aclk);
			rxv <= 1'b1;
			rxd <= rows[i].rx;
			do @(posedge aclk); while (!rxr);
			rxv <= 1'b0;
			ext.rd(b);
			`CHK("rx byte", rows[i].rx, b)
			ext.wr(rows[i].tx);
			while (!txv) @(posedge aclk);
			`CHK("tx byte", rows[i].tx, txd)
			txr <= 1'b1;
			@(posedge aclk);
			txr <= 1'b0;
		end
		pins(1'b0, 1'b0, 1'b0);
		rdchk(UFP_OFF_STAT, 32'h1, UFP_RESP_OKAY);
		rdchk(UFP_OFF_CNT, 32'h0004_0004, UFP_RESP_OKAY);
		rdchk(8'h10, 32'h0, UFP_RESP_SLVERR);
		axw(UFP_OFF_CFG, 32'h1, UFP_RESP_OKAY);
		ws <= 4'h0;
		axw(UFP_OFF_CFG, 32'h0, UFP_RESP_OKAY);
		rdchk(UFP_OFF_CFG, 32'h1, UFP_RESP_OKAY);
		ws <= 4'hf;
		axw(8'h10, 32'h3, UFP_RESP_SLVERR);
		rdchk(UFP_OFF_CFG, 32'h1, UFP_RESP_OKAY);
		susp <= 1'b1;
		pins(1'b1, 1'b1, 1'b0);
		ext.wake(8);
		repeat (3) @(posedge aclk);
		`CHK("short wake", 0, n_res)
		ext.wake(24);
		repeat (3) @(posedge aclk);
		`CHK("long wake", 1, n_res)
		rdchk(UFP_OFF_ERR, 32'h4, UFP_RESP_OKAY);
		axw(UFP_OFF_ERR, 32'h4, UFP_RESP_OKAY);
		rdchk(UFP_OFF_ERR, 32'h0, UFP_RESP_OKAY);
		axw(UFP_OFF_CFG, 32'h3, UFP_RESP_OKAY);
		rdchk(UFP_OFF_CFG, 32'h3, UFP_RESP_OKAY);
		pins(1'b1, 1'b1, 1'b1);
		susp <= 1'b0;
		pins(1'b0, 1'b0, 1'b0);
		// reset again in mid-run
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		`CHK("rst tx oe", 1'b1, pin_o.tx_space_flag_oe_n)
		`CHK("rst rx oe", 1'b1, pin_o.rx_data_flag_oe_n)
		`CHK("rst power", 1'b1, pin_o.power_enable_n)
		aresetn <= 1'b1;
		pins(1'b0, 1'b0, 1'b0);
		rdchk(UFP_OFF_CFG, 32'h0, UFP_RESP_OKAY);
		results();
	end
endmodule
`default_nettype wire
